// file: sca_map.svh
// register offsets, field positions, widths and reset values for channel a
`ifndef SCA_MAP_SVH
`define SCA_MAP_SVH
`define SCA_ADDR_W          8
`define SCA_OFF_ENABLE      8'h00
`define SCA_OFF_MODE        8'h04
`define SCA_OFF_FORMAT      8'h08
`define SCA_OFF_START_LINE  8'h0C
`define SCA_OFF_START_PIXEL 8'h10
`define SCA_OFF_LINE_COUNT  8'h14
`define SCA_OFF_LINE_WIDTH  8'h18
`define SCA_OFF_LUMA_PHASE  8'h1C
`define SCA_OFF_CHROMA_PHASE 8'h20
`define SCA_OFF_SCALE       8'h24
`define SCA_OFF_STATUS      8'h28
`define SCA_FMT_LUMA_BIT    0
`define SCA_FMT_CHROMA_BIT  1
`define SCA_GEOM_W          13
`define SCA_PHASE_W         14
`define SCA_RST_WIDTH       13'h0001
`define SCA_RST_SCALE       14'h0100
`define SCA_DOWN_MIN        14'h0100
`define SCA_SCALE_MAX       14'h1000
`define SCA_FIFO_DEPTH      16
`define SCA_DATA_W          16
`endif

// file: sca_pkg.sv
// types shared by the channel a geometry block
package sca_pkg;
    typedef enum logic [1:0] {SCA_IDLE, SCA_SKIP, SCA_RUN, SCA_DONE} sca_state_e;
    typedef logic [12:0] sca_geom_t;
    typedef logic [13:0] sca_phase_t;
endpackage : sca_pkg

// file: sca_fifo.sv
// small parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sca_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } sca_fifo_s;
    sca_fifo_s st_q;
    sca_fifo_s st_d;
    logic push;
    logic pop;

    assign in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st_q.cnt != '0);
    assign out_data  = st_q.mem[st_q.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        st_d = st_q;
        if (push)
        begin
            st_d.mem[st_q.wr] = in_data;
            st_d.wr = st_q.wr + 1'b1;
        end
        if (pop)
            st_d.rd = st_q.rd + 1'b1;
        if (push && !pop)
            st_d.cnt = st_q.cnt + 1'b1;
        else if (pop && !push)
            st_d.cnt = st_q.cnt - 1'b1;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end
endmodule : sca_fifo
`default_nettype wire

// file: sca_geom.sv
// channel a frame geometry: crop, output size, format and phase seeding
// What this block does
// RULE_01: chroma enable 1 passes chroma and turns on 4:2:0 conversion; 0 drops chroma.
// RULE_02: luma enable 1 passes luma and turns on 4:2:0 conversion; 0 drops luma.
// RULE_03: both enables zero gives plain 4:2:2; enables act only on 4:2:2 input.
// RULE_04: 13-bit line crop offset picks first processed line after source start.
// RULE_05: 13-bit pixel crop offset picks first processed pixel after source start.
// RULE_06: pixel crop bit 0 ignores writes, offset stays even.
// RULE_07: output lines per image equal line count field plus one.
// RULE_08: output pixels per line equal width field plus one.
// RULE_09: width bit 0 ignores writes and stays one.
// RULE_10: software keeps width within 2176 normal, 1088 down-scale.
// RULE_11: 14-bit luma phase seeds vertical luma accumulator each image.
// RULE_12: 14-bit chroma phase seeds vertical chroma accumulator each image.
// RULE_13: software keeps both phases zero except frame-division use.
// RULE_14: reserved bits are written zero and read back zero.
// RULE_15: scale 256 to 4096 is down-scale mode; 16 to 4096 normal.
// RULE_16: one-shot clears enable at vertical sync; otherwise enable gates output.
// RULE_17: geometry settings are sampled at each vertical sync.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sca_map.svh"
module sca_geom (
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    input  wire logic [`SCA_ADDR_W-1:0]    reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    output logic      [31:0]               reg_rdata,
    input  wire logic                      in_is_422,
    input  wire logic                      vertical_sync,
    input  wire logic                      in_line_start,
    input  wire logic                      in_valid,
    input  wire logic [`SCA_DATA_W-1:0]    in_data,
    input  wire logic                      in_is_chroma,
    output logic                           in_ready,
    output logic                           out_valid,
    input  wire logic                      out_ready,
    output logic      [`SCA_DATA_W-1:0]    out_data,
    output logic                           out_420_mode,
    output logic                           out_down_scale,
    output logic      [13:0]               luma_phase_seed,
    output logic      [13:0]               chroma_phase_seed,
    output logic                           frame_done
);
    import sca_pkg::*;

    typedef struct packed {
        logic                        enable;
        logic                        one_shot;
        logic                        luma_out_enable;
        logic                        chroma_out_enable;
        sca_pkg::sca_geom_t          start_line;
        sca_pkg::sca_geom_t          start_pixel;
        sca_pkg::sca_geom_t          line_count;
        sca_pkg::sca_geom_t          line_width;
        sca_pkg::sca_phase_t         luma_phase;
        sca_pkg::sca_phase_t         chroma_phase;
        sca_pkg::sca_phase_t         scale;
        sca_pkg::sca_geom_t          act_line;
        sca_pkg::sca_geom_t          act_pixel;
        sca_pkg::sca_geom_t          act_lcount;
        sca_pkg::sca_geom_t          act_width;
        logic                        act_fmt420;
        logic                        act_luma;
        logic                        act_chroma;
        logic                        act_en;
        sca_pkg::sca_state_e         state;
        sca_pkg::sca_geom_t          src_line;
        sca_pkg::sca_geom_t          src_pix;
        sca_pkg::sca_geom_t          out_line;
        sca_pkg::sca_geom_t          out_pix;
        logic                        pend_line;
        logic                        wr_valid;
        logic [`SCA_DATA_W-1:0]      wr_data;
        logic [31:0]                 rdata;
        logic [1:0]                  vs_sync;
        logic [1:0]                  ls_sync;
        logic                        vs_seen;
        logic                        ls_seen;
        logic                        o_420;
        logic                        o_down;
        sca_pkg::sca_phase_t         o_lph;
        sca_pkg::sca_phase_t         o_cph;
        logic                        o_done;
        logic                        o_valid;
        logic [`SCA_DATA_W-1:0]      o_data;
    } sca_geom_s;

    sca_geom_s st_q;
    sca_geom_s st_d;
    logic      fifo_in_ready;
    logic      fifo_out_valid;
    logic [`SCA_DATA_W-1:0] fifo_out_data;
    logic      vs_rise;
    logic      ls_rise;
    logic      take;
    logic      keep;
    logic      out_take;

    // strobes are pins: two flops before the edge detector
    assign vs_rise  = st_q.vs_sync[1] && !st_q.vs_seen;
    assign ls_rise  = st_q.ls_sync[1] && !st_q.ls_seen;
    assign in_ready = fifo_in_ready && !st_q.wr_valid;
    assign take     = in_valid && in_ready;
    // the fifo drain stalls while the output register is held
    assign out_take = fifo_out_valid && (!st_q.o_valid || out_ready);

    always_comb
    begin
        st_d = st_q;
        keep = 1'b0;
        st_d.vs_sync  = {st_q.vs_sync[0], vertical_sync};
        st_d.ls_sync  = {st_q.ls_sync[0], in_line_start};
        st_d.vs_seen  = st_q.vs_sync[1];
        st_d.ls_seen  = st_q.ls_sync[1];
        st_d.rdata    = 32'h0000_0000;
        st_d.o_done   = 1'b0;
        if (fifo_in_ready)
            st_d.wr_valid = 1'b0;

        // register writes; reserved bits are dropped [RULE_14]
        if (reg_write)
        begin
            if (reg_addr == `SCA_OFF_ENABLE)
                st_d.enable = reg_wdata[0];
            else if (reg_addr == `SCA_OFF_MODE)
                st_d.one_shot = reg_wdata[0];
            else if (reg_addr == `SCA_OFF_FORMAT)
            begin
                st_d.luma_out_enable   = reg_wdata[`SCA_FMT_LUMA_BIT];
                st_d.chroma_out_enable = reg_wdata[`SCA_FMT_CHROMA_BIT];
            end
            else if (reg_addr == `SCA_OFF_START_LINE)
                st_d.start_line = reg_wdata[12:0];
            else if (reg_addr == `SCA_OFF_START_PIXEL)
                st_d.start_pixel = {reg_wdata[12:1], 1'b0}; // [RULE_06]
            else if (reg_addr == `SCA_OFF_LINE_COUNT)
                st_d.line_count = reg_wdata[12:0];
            else if (reg_addr == `SCA_OFF_LINE_WIDTH)
                st_d.line_width = {reg_wdata[12:1], 1'b1}; // [RULE_09]
            else if (reg_addr == `SCA_OFF_LUMA_PHASE)
                st_d.luma_phase = reg_wdata[13:0];
            else if (reg_addr == `SCA_OFF_CHROMA_PHASE)
                st_d.chroma_phase = reg_wdata[13:0];
            else if (reg_addr == `SCA_OFF_SCALE)
                st_d.scale = reg_wdata[13:0];
        end

        // reads answer one cycle later; unmapped reads as zero [RULE_14]
        if (reg_read)
        begin
            if (reg_addr == `SCA_OFF_ENABLE)
                st_d.rdata = {31'h0, st_q.enable};
            else if (reg_addr == `SCA_OFF_MODE)
                st_d.rdata = {31'h0, st_q.one_shot};
            else if (reg_addr == `SCA_OFF_FORMAT)
                st_d.rdata = {30'h0, st_q.chroma_out_enable,
                              st_q.luma_out_enable};
            else if (reg_addr == `SCA_OFF_START_LINE)
                st_d.rdata = {19'h0, st_q.start_line};
            else if (reg_addr == `SCA_OFF_START_PIXEL)
                st_d.rdata = {19'h0, st_q.start_pixel};
            else if (reg_addr == `SCA_OFF_LINE_COUNT)
                st_d.rdata = {19'h0, st_q.line_count};
            else if (reg_addr == `SCA_OFF_LINE_WIDTH)
                st_d.rdata = {19'h0, st_q.line_width};
            else if (reg_addr == `SCA_OFF_LUMA_PHASE)
                st_d.rdata = {18'h0, st_q.luma_phase};
            else if (reg_addr == `SCA_OFF_CHROMA_PHASE)
                st_d.rdata = {18'h0, st_q.chroma_phase};
            else if (reg_addr == `SCA_OFF_SCALE)
                st_d.rdata = {18'h0, st_q.scale};
            else if (reg_addr == `SCA_OFF_STATUS)
                st_d.rdata = {3'h0, st_q.out_line, 1'b0, st_q.out_pix,
                              (st_q.state == SCA_DONE), st_q.act_en};
        end

        // down-scale flag: scale in 256..4096 [RULE_15]
        st_d.o_down = (st_q.scale >= `SCA_DOWN_MIN)
                   && (st_q.scale <= `SCA_SCALE_MAX);

        if (vs_rise)
        begin
            // latch the shadow set once per image [RULE_17]
            st_d.act_line   = st_q.start_line;
            st_d.act_pixel  = st_q.start_pixel;
            st_d.act_lcount = st_q.line_count;
            st_d.act_width  = st_q.line_width;
            st_d.o_lph      = st_q.luma_phase;   // [RULE_11]
            st_d.o_cph      = st_q.chroma_phase; // [RULE_12]
            // enables only matter for 4:2:2 input [RULE_03]
            st_d.act_fmt420 = in_is_422 && (st_q.luma_out_enable
                                         || st_q.chroma_out_enable);
            st_d.act_luma   = !st_d.act_fmt420 || st_q.luma_out_enable;
            st_d.act_chroma = !st_d.act_fmt420 || st_q.chroma_out_enable;
            st_d.o_420      = st_d.act_fmt420; // [RULE_01] [RULE_02]
            st_d.act_en     = st_q.enable;     // [RULE_16]
            if (st_q.one_shot && !(reg_write
                && reg_addr == `SCA_OFF_ENABLE && reg_wdata[0]))
                st_d.enable = 1'b0; // [RULE_16]
            st_d.src_line  = '0;
            st_d.src_pix   = '0;
            st_d.out_line  = '0;
            st_d.out_pix   = '0;
            st_d.pend_line = 1'b0;
            st_d.state     = st_q.enable ? SCA_SKIP : SCA_IDLE;
        end
        else
        begin
            if (ls_rise && st_q.state != SCA_IDLE)
            begin
                st_d.src_pix = '0;
                if (st_q.pend_line)
                    st_d.src_line = st_q.src_line + 13'h0001;
                st_d.pend_line = 1'b1;
                if (st_q.state == SCA_RUN && st_q.out_pix != '0)
                begin
                    st_d.out_pix  = '0;
                    st_d.out_line = st_q.out_line + 13'h0001;
                end
            end
            case (st_q.state)
                SCA_IDLE: ;
                SCA_SKIP:
                    // first line counted from source start [RULE_04]
                    if (st_d.src_line == st_q.act_line && st_d.pend_line)
                        st_d.state = SCA_RUN;
                SCA_RUN:
                    if (take)
                    begin
                        st_d.src_pix = st_q.src_pix + 13'h0001;
                        // crop start pixel, width+1 pixels [RULE_05] [RULE_08]
                        if (st_q.src_pix >= st_q.act_pixel
                            && st_q.out_pix <= st_q.act_width)
                        begin
                            keep = in_is_chroma ? st_q.act_chroma
                                                : st_q.act_luma;
                            st_d.out_pix = st_q.out_pix + 13'h0001;
                            // line count+1 lines then stop [RULE_07]
                            if (st_q.out_pix == st_q.act_width
                                && st_q.out_line == st_q.act_lcount)
                            begin
                                st_d.state  = SCA_DONE;
                                st_d.o_done = 1'b1;
                            end
                        end
                    end
                SCA_DONE: ;
                default: st_d.state = SCA_IDLE;
            endcase
        end
        // [RULE_01] [RULE_02] [RULE_16]
        if (take && keep && st_q.act_en)
        begin
            st_d.wr_valid = 1'b1;
            st_d.wr_data  = in_data;
        end

        if (out_take)
        begin
            st_d.o_valid = 1'b1;
            st_d.o_data  = fifo_out_data;
        end
        else if (out_ready)
            st_d.o_valid = 1'b0;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q            <= '0;
            st_q.line_width <= `SCA_RST_WIDTH;
            st_q.act_width  <= `SCA_RST_WIDTH;
            st_q.scale      <= `SCA_RST_SCALE;
            st_q.state      <= SCA_IDLE;
        end
        else
            st_q <= st_d;
    end

    sca_fifo #(
        .WIDTH (`SCA_DATA_W),
        .DEPTH (`SCA_FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (st_q.wr_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (st_q.wr_data),
        .out_valid (fifo_out_valid),
        .out_ready (!st_q.o_valid || out_ready),
        .out_data  (fifo_out_data)
    );

    assign reg_rdata         = st_q.rdata;
    assign out_valid         = st_q.o_valid;
    assign out_data          = st_q.o_data;
    assign out_420_mode      = st_q.o_420;
    assign out_down_scale    = st_q.o_down;
    assign luma_phase_seed   = st_q.o_lph;
    assign chroma_phase_seed = st_q.o_cph;
    assign frame_done        = st_q.o_done;

    property p_hsize_lsb;
        @(posedge clock) disable iff (!rst_n)
        st_q.line_width[0] == 1'b1;
    endproperty
    a_hsize_lsb: assert property (p_hsize_lsb) // [RULE_09]
        else $error("width bit 0 not one");

    property p_hstart_even;
        @(posedge clock) disable iff (!rst_n)
        reg_write && reg_addr == `SCA_OFF_START_PIXEL
        |=> st_q.start_pixel == {$past(reg_wdata[12:1]), 1'b0};
    endproperty
    a_hstart_even: assert property (p_hstart_even) // [RULE_06]
        else $error("start pixel write not even");

    sequence s_vs_edge;
        vs_rise;
    endsequence
    property p_seed_luma;
        @(posedge clock) disable iff (!rst_n)
        s_vs_edge |=> luma_phase_seed == $past(st_q.luma_phase);
    endproperty
    a_seed_luma: assert property (p_seed_luma) // [RULE_11]
        else $error("luma phase not seeded");

    property p_seed_chroma;
        @(posedge clock) disable iff (!rst_n)
        s_vs_edge |=> chroma_phase_seed == $past(st_q.chroma_phase);
    endproperty
    a_seed_chroma: assert property (p_seed_chroma) // [RULE_12]
        else $error("chroma phase not seeded");

    property p_oneshot;
        @(posedge clock) disable iff (!rst_n)
        s_vs_edge and st_q.one_shot and !reg_write |=> !st_q.enable;
    endproperty
    a_oneshot: assert property (p_oneshot) // [RULE_16]
        else $error("one-shot enable not cleared");

    property p_fmt;
        @(posedge clock) disable iff (!rst_n)
        s_vs_edge ##1 1'b1 |-> out_420_mode == ($past(in_is_422, 1)
            && ($past(st_q.luma_out_enable, 1)
            || $past(st_q.chroma_out_enable, 1)));
    endproperty
    a_fmt: assert property (p_fmt) // [RULE_03]
        else $error("format latch wrong");

    property p_read_zero;
        @(posedge clock) disable iff (!rst_n)
        reg_read && reg_addr == `SCA_OFF_FORMAT |=> reg_rdata[31:2] == '0;
    endproperty
    a_read_zero: assert property (p_read_zero) // [RULE_14]
        else $error("reserved bits not zero");

    property p_down;
        @(posedge clock) disable iff (!rst_n)
        st_q.scale >= 14'h0100 && st_q.scale <= 14'h1000 |=> out_down_scale;
    endproperty
    a_down: assert property (p_down) // [RULE_15]
        else $error("down-scale flag missing");
endmodule : sca_geom
`default_nettype wire

// file: sca_partner.sv
// upstream pixel source and downstream memory sink facing channel a
`timescale 1ns/1ps
`default_nettype none
module sca_partner (
    input  wire logic        clock,
    output logic             vertical_sync,
    output logic             in_line_start,
    output logic             in_valid,
    output logic [15:0]      in_data,
    output logic             in_is_chroma,
    input  wire logic        in_ready,
    input  wire logic        out_valid,
    output logic             out_ready,
    input  wire logic [15:0] out_data,
    input  wire logic        hold_out
);
    int          n_words;
    int          cyc;
    logic [15:0] first_word;
    logic        refused;
    // the sink stalls every third cycle so the output must hold its word
    assign out_ready = !hold_out && (cyc % 3 != 2);
    initial
    begin
        vertical_sync = 1'b0;
        in_line_start = 1'b0;
        in_valid = 1'b0;
        in_data = 16'h0000;
        in_is_chroma = 1'b0;
        cyc = 0;
        clear();
    end
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (out_valid === 1'b1 && out_ready)
        begin
            if (n_words == 0)
                first_word <= out_data;
            n_words <= n_words + 1;
        end
        if (in_valid && in_ready !== 1'b1)
            refused <= 1'b1;
    end
    task automatic clear();
        n_words = 0;
        first_word = 16'hFFFF;
        refused = 1'b0;
    endtask : clear
    task automatic sync_edge();
        @(posedge clock);
        vertical_sync <= 1'b1;
        repeat (4) @(posedge clock);
        vertical_sync <= 1'b0;
        repeat (8) @(posedge clock);
    endtask : sync_edge
    task automatic line_edge();
        @(posedge clock);
        in_line_start <= 1'b1;
        repeat (4) @(posedge clock);
        in_line_start <= 1'b0;
        repeat (4) @(posedge clock);
    endtask : line_edge
    // pixel word carries its own line and pixel index for the checks
    task automatic send_frame(input int lines, input int pix);
        sync_edge();
        for (int l = 0; l < lines; l++)
        begin
            line_edge();
            for (int p = 0; p < pix; p++)
            begin
                in_valid <= 1'b1;
                in_data <= {l[7:0], p[7:0]};
                in_is_chroma <= p[0];
                do @(posedge clock); while (in_ready !== 1'b1);
            end
            in_valid <= 1'b0;
            in_data <= ~in_data;
        end
        line_edge();
    endtask : send_frame
endmodule : sca_partner
`default_nettype wire

// file: sca_geom_bench.sv
// self-checking bench for the channel a geometry block
`timescale 1ns/1ps
`default_nettype none
`include "sca_map.svh"
module sca_geom_bench;
    logic        clock, rst_n, reg_write, reg_read, in_is_422, hold_out;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic        vertical_sync, in_line_start, in_valid, in_is_chroma;
    logic        in_ready, out_valid, out_ready, frame_done;
    logic [15:0] in_data, out_data;
    logic        out_420_mode, out_down_scale;
    logic [13:0] luma_phase_seed, chroma_phase_seed;
    int          n_errors, n_compared, n_done, cycles;
    localparam logic [7:0]  OFFS [7] = '{`SCA_OFF_FORMAT, `SCA_OFF_START_LINE,
        `SCA_OFF_START_PIXEL, `SCA_OFF_LINE_COUNT, `SCA_OFF_LINE_WIDTH,
        `SCA_OFF_LUMA_PHASE, `SCA_OFF_CHROMA_PHASE};
    localparam logic [31:0] RSTV [7] = '{0, 0, 0, 0, 1, 0, 0};
    localparam logic [31:0] ONES [7] = '{32'h3, 32'h1FFF, 32'h1FFE, 32'h1FFF,
        32'h1FFF, 32'h3FFF, 32'h3FFF};

    sca_geom dut_u (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .in_is_422(in_is_422),
        .vertical_sync(vertical_sync), .in_line_start(in_line_start),
        .in_valid(in_valid), .in_data(in_data), .in_is_chroma(in_is_chroma),
        .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .out_420_mode(out_420_mode),
        .out_down_scale(out_down_scale), .luma_phase_seed(luma_phase_seed),
        .chroma_phase_seed(chroma_phase_seed), .frame_done(frame_done));
    sca_partner partner_u (.clock(clock), .vertical_sync(vertical_sync),
        .in_line_start(in_line_start), .in_valid(in_valid),
        .in_data(in_data), .in_is_chroma(in_is_chroma), .in_ready(in_ready),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .hold_out(hold_out));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // generous ceiling: the whole sequence needs under two thousand cycles
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (frame_done === 1'b1)
            n_done <= n_done + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe is taken
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    task automatic close_out();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    initial
    begin
        {reg_write, reg_read, reg_addr, reg_wdata, hold_out} = '0;
        {n_errors, n_compared, n_done, cycles} = '0;
        in_is_422 = 1'b1;
        rst_n = 1'b0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd(OFFS[i], RSTV[i]);
        for (int i = 0; i < 7; i++)
        begin
            wr(OFFS[i], ONES[i] | 32'h1);
            rd(OFFS[i], ONES[i]);
            wr(OFFS[i], 32'h0);
            rd(OFFS[i], RSTV[i]);
        end
        wr(8'hFC, 32'h5A5A_5A5A);
        rd(8'hFC, 32'h0);
        // frame a: crop one line and two pixels, three lines of four
        wr(`SCA_OFF_ENABLE, 32'h1);
        wr(`SCA_OFF_START_LINE, 32'h1);
        wr(`SCA_OFF_START_PIXEL, 32'h2);
        wr(`SCA_OFF_LINE_COUNT, 32'h2);
        wr(`SCA_OFF_LINE_WIDTH, 32'h3);
        wr(`SCA_OFF_LUMA_PHASE, 32'h2710);
        wr(`SCA_OFF_CHROMA_PHASE, 32'h1234);
        partner_u.send_frame(6, 8);
        repeat (100) @(posedge clock);
        chk(partner_u.n_words, 12);
        chk(partner_u.first_word, 32'h0102);
        chk(n_done, 1);
        rd(`SCA_OFF_STATUS, 32'h0002_0013);
        chk(luma_phase_seed, 32'h2710);
        chk(chroma_phase_seed, 32'h1234);
        // a change between syncs must wait for the next image
        wr(`SCA_OFF_LUMA_PHASE, 32'h5);
        repeat (5) @(posedge clock);
        chk(luma_phase_seed, 32'h2710);
        partner_u.sync_edge();
        chk(luma_phase_seed, 32'h5);
        for (int f = 0; f < 4; f++)
        begin
            wr(`SCA_OFF_FORMAT, f);
            partner_u.sync_edge();
            chk(out_420_mode, f != 0);
        end
        in_is_422 <= 1'b0;
        partner_u.sync_edge();
        chk(out_420_mode, 0);
        in_is_422 <= 1'b1;
        wr(`SCA_OFF_FORMAT, 32'h0);
        wr(`SCA_OFF_SCALE, 32'h100);
        partner_u.sync_edge();
        chk(out_down_scale, 1);
        wr(`SCA_OFF_SCALE, 32'hFF);
        partner_u.sync_edge();
        chk(out_down_scale, 0);
        // frame c: sink held off long enough for the fifo to refuse
        wr(`SCA_OFF_LUMA_PHASE, 32'h0);
        wr(`SCA_OFF_CHROMA_PHASE, 32'h0);
        wr(`SCA_OFF_START_LINE, 32'h0);
        wr(`SCA_OFF_START_PIXEL, 32'h3);
        rd(`SCA_OFF_START_PIXEL, 32'h2);
        wr(`SCA_OFF_START_PIXEL, 32'h0);
        wr(`SCA_OFF_LINE_COUNT, 32'h1);
        wr(`SCA_OFF_LINE_WIDTH, 32'hE);
        partner_u.clear();
        hold_out <= 1'b1;
        fork
            partner_u.send_frame(3, 18);
            begin
                repeat (300) @(posedge clock);
                hold_out <= 1'b0;
            end
        join
        repeat (150) @(posedge clock);
        chk(partner_u.refused, 1);
        chk(partner_u.n_words, 32);
        chk(partner_u.first_word, 32'h0000);
        chk(n_done, 2);
        // chroma only: odd samples of two 16-pixel lines pass
        wr(`SCA_OFF_FORMAT, 32'h2);
        partner_u.clear();
        partner_u.send_frame(3, 18);
        repeat (100) @(posedge clock);
        chk(partner_u.n_words, 16);
        chk(partner_u.first_word, 32'h0001);
        wr(`SCA_OFF_MODE, 32'h1);
        partner_u.sync_edge();
        rd(`SCA_OFF_ENABLE, 32'h0);
        partner_u.clear();
        partner_u.send_frame(3, 18);
        repeat (100) @(posedge clock);
        chk(partner_u.n_words, 0);
        close_out();
    end
endmodule : sca_geom_bench
`default_nettype wire
